/* common/typec_port_consts.svh */
// Summary of operation
// - pull fault low on deglitched overcurrent or lower thermal threshold crossing.
// - keep fault asserted until the condition clears and normal operation resumes.
// - overcurrent passes a deglitch filter so short excursions raise no fault.
// - above the lower thermal threshold, switch off the charging switch and assert fault.
// - above the higher thermal threshold, release every open-drain output and shut down.
// - after thermal shutdown, restart once the die has cooled by the hysteresis.
// - drive audio output low when both CC lines see Ra.
// - watch only CC2 for audio removal; release audio once Ra leaves CC2.
// - drive debug output low when both CC lines see Rd.
// - watch only CC1 for debug removal; release debug once Rd leaves CC1.
// - orientation output stays released whenever no UFP is attached.
// - with a UFP, orientation released for Rd on CC1, low for Rd on CC2.
// - enable low opens both supply switches, releases outputs, stops CC monitoring.
// - the device runs with enable high; the outside must always drive enable.
// - assert the active-low high-current flag while UFP load exceeds 1.95 A.
// - pull the attached-UFP output low whenever a UFP is detected.
// - turn on the charging switch after a UFP is detected and deglitched.
// - with Ra on the CC line away from the UFP, power that line from cable supply.
`ifndef TYPEC_PORT_CONSTS_SVH
`define TYPEC_PORT_CONSTS_SVH

`define CLK_PERIOD_NS       20
`define OC_DEGLITCH_NS      8000
`define OC_DEGLITCH_CYC     ((`OC_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ATTACH_DEGLITCH_NS  40000
`define ATTACH_DEGLITCH_CYC ((`ATTACH_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define THERMAL_HYST_DEGC   20
`define HICUR_THRESH_MA     1950

`define REG_STATUS     8'h00
`define REG_MASK       8'h04
`define REG_CTRL       8'h08
`define REG_STATE      8'h0C

`define CTRL_EN_BIT    0
`define CTRL_VCONN_BIT 1
`define CTRL_RESET     2'h3

`define EV_ATTACH      0
`define EV_DETACH      1
`define EV_FAULT       2
`define EV_AUDIO       3
`define EV_DEBUG       4
`define EV_SHUTDOWN    5
`define EV_W           6

`endif

/* common/typec_port_pkg.sv */
package typec_port_pkg;
  typedef enum logic [1:0] {
    CC_OPEN = 2'b00,
    CC_RA   = 2'b01,
    CC_RD   = 2'b10
  } cc_term_e;

  typedef enum logic [2:0] {
    TH_RUN  = 3'b001,
    TH_HOLD = 3'b010,
    TH_SHUT = 3'b100
  } therm_e;
endpackage

/* core/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // pins
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } sync_s;

  sync_s r;
  sync_s n;

  always_comb begin
    n.meta = i_async;
    n.held = r.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_sync = r.held;
endmodule
`default_nettype wire

/* core/deglitch.sv */
`timescale 1ns/1ns
`default_nettype none
module deglitch #(
  parameter int CYC = 4
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // level in and filtered level out
  input  wire logic i_in,
  output logic      o_out
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        out;
  } dg_s;

  localparam logic [11:0] LAST = 12'(CYC - 1);

  dg_s r;
  dg_s n;

  // rises only after the input held CYC cycles, falls at once
  always_comb begin
    n = r;
    if (!i_in) begin
      n.cnt = 12'h000;
      n.out = 1'b0;
    end else if (r.cnt == LAST) begin
      n.out = 1'b1;
    end else begin
      n.cnt = r.cnt + 12'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_out = r.out;
endmodule
`default_nettype wire

/* core/typec_source_port_status.sv */
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "typec_port_consts.svh"
module typec_source_port_status
  import typec_port_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // connector and analog comparators
  input  wire logic [1:0]  i_cc1,
  input  wire logic [1:0]  i_cc2,
  input  wire logic        i_en,
  input  wire logic        i_overcurrent,
  input  wire logic        i_thermal_low,
  input  wire logic        i_thermal_high,
  input  wire logic        i_thermal_cooled,
  input  wire logic        i_load_high,
  // open-drain pull-down requests, low drives the pin
  output logic             o_fault_n,
  output logic             o_plug_orientation_n,
  output logic             o_ufp_n,
  output logic             o_audio_n,
  output logic             o_debug_n,
  output logic             o_high_current_n,
  // supply switches
  output logic             o_charging_supply_on,
  output logic             o_cable_power_cc1_on,
  output logic             o_cable_power_cc2_on,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // interrupt
  output logic             o_irq
);

  // ********************************
  // reset and pin synchronisers
  // ********************************
  logic [1:0] rst_pipe;
  logic       rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_b = rst_pipe[1];

  logic [9:0]  pins_s;
  logic [1:0]  s_cc1;
  logic [1:0]  s_cc2;
  logic        s_en;
  logic        s_oc;
  logic        s_th_lo;
  logic        s_th_hi;
  logic        s_cooled;
  logic        s_load_hi;

  pin_sync #(.W(10)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_async ({i_cc1, i_cc2, i_en, i_overcurrent, i_thermal_low,
               i_thermal_high, i_thermal_cooled, i_load_high}),
    .o_sync  (pins_s)
  );
  assign {s_cc1, s_cc2, s_en, s_oc, s_th_lo, s_th_hi, s_cooled, s_load_hi} = pins_s;

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    therm_e              th;
    logic                audio;
    logic                debug;
    logic [`EV_W-1:0]    status;
    logic [`EV_W-1:0]    mask;
    logic [1:0]          ctrl;
    logic                irq;
    logic                fault_n;
    logic                orient_n;
    logic                ufp_n;
    logic                audio_n;
    logic                debug_n;
    logic                hicur_n;
    logic                chg_on;
    logic                vconn1;
    logic                vconn2;
    logic                ap_valid;
    logic                ap_write;
    logic [7:0]          ap_addr;
    logic [31:0]         hrdata;
    logic                hready;
    logic                hresp;
  } port_s;

  localparam port_s RESET_S = '{
    th: TH_RUN, audio: 1'b0, debug: 1'b0, status: '0, mask: '0,
    ctrl: `CTRL_RESET, irq: 1'b0, fault_n: 1'b1, orient_n: 1'b1, ufp_n: 1'b1,
    audio_n: 1'b1, debug_n: 1'b1, hicur_n: 1'b1, chg_on: 1'b0, vconn1: 1'b0,
    vconn2: 1'b0, ap_valid: 1'b0, ap_write: 1'b0, ap_addr: 8'h00,
    hrdata: 32'h0000_0000, hready: 1'b1, hresp: 1'b0};

  port_s r;
  port_s n;

  logic en_eff;
  logic gate;
  logic ufp_cand;
  logic ufp_dg;
  logic ufp;
  logic oc_dg;
  logic fault;
  logic acc;
  logic [`EV_W-1:0] ev;

  // enable pin and software enable must both be high; the pin is never left floating
  assign en_eff   = s_en && r.ctrl[`CTRL_EN_BIT];
  assign gate     = en_eff && (r.th != TH_SHUT);
  // exactly one Rd; Rd on both is a debug accessory, not a UFP
  assign ufp_cand = gate && ((s_cc1 == CC_RD) ^ (s_cc2 == CC_RD));
  assign ufp      = ufp_dg && ufp_cand;
  assign acc      = i_hsel && i_hready && i_htrans[1];

  // ********************************
  // deglitch filters
  // ********************************
  deglitch #(.CYC(`ATTACH_DEGLITCH_CYC)) u_attach_dg (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_in    (ufp_cand),
    .o_out   (ufp_dg)
  );

  // short current spikes never reach the fault pin
  deglitch #(.CYC(`OC_DEGLITCH_CYC)) u_oc_dg (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_in    (s_oc),
    .o_out   (oc_dg)
  );

  // ********************************
  // next state
  // ********************************
  always_comb begin
    n = r;
    fault = 1'b0;
    ev = '0;

    // lower trip holds the switch off, higher trip shuts down until cooled
    unique case (r.th)
      TH_RUN: begin
        if (s_th_hi) begin
          n.th = TH_SHUT;
        end else if (s_th_lo) begin
          n.th = TH_HOLD;
        end
      end
      TH_HOLD: begin
        if (s_th_hi) begin
          n.th = TH_SHUT;
        end else if (!s_th_lo) begin
          n.th = TH_RUN;
        end
      end
      TH_SHUT: begin
        if (s_cooled) begin
          n.th = TH_RUN;
        end
      end
    endcase

    // cc monitor is off while disabled, so accessories drop at once
    if (!gate) begin
      n.audio = 1'b0;
      n.debug = 1'b0;
    end else begin
      if (s_cc1 == CC_RA && s_cc2 == CC_RA) begin
        n.audio = 1'b1;
      end else if (s_cc2 != CC_RA) begin
        n.audio = 1'b0;
      end
      if (s_cc1 == CC_RD && s_cc2 == CC_RD) begin
        n.debug = 1'b1;
      end else if (s_cc1 != CC_RD) begin
        n.debug = 1'b0;
      end
    end

    // pin requests: high releases the pin to its pullup
    n.ufp_n    = !ufp;
    n.orient_n = !(ufp && s_cc2 == CC_RD);
    n.audio_n  = !n.audio;
    n.debug_n  = !n.debug;

    n.chg_on = ufp && (r.th == TH_RUN);
    n.vconn1 = ufp && (r.th == TH_RUN) && r.ctrl[`CTRL_VCONN_BIT]
               && s_cc2 == CC_RD && s_cc1 == CC_RA;
    n.vconn2 = ufp && (r.th == TH_RUN) && r.ctrl[`CTRL_VCONN_BIT]
               && s_cc1 == CC_RD && s_cc2 == CC_RA;

    // fault stands while the cause stands, released as soon as it clears
    fault = gate && ((oc_dg && r.chg_on) || r.th == TH_HOLD);
    n.fault_n = !fault;
    n.hicur_n = !(gate && r.chg_on && s_load_hi);

    ev[`EV_ATTACH]   = ufp && r.ufp_n;
    ev[`EV_DETACH]   = !ufp && !r.ufp_n;
    ev[`EV_FAULT]    = fault && r.fault_n;
    ev[`EV_AUDIO]    = n.audio && !r.audio;
    ev[`EV_DEBUG]    = n.debug && !r.debug;
    ev[`EV_SHUTDOWN] = (n.th == TH_SHUT) && (r.th != TH_SHUT);

    // bus data phase; writes of any size take the whole word
    if (r.ap_valid && r.ap_write) begin
      unique case (r.ap_addr)
        `REG_STATUS: n.status = r.status & ~i_hwdata[`EV_W-1:0];
        `REG_MASK:   n.mask = i_hwdata[`EV_W-1:0];
        `REG_CTRL:   n.ctrl = i_hwdata[1:0];
        default:     n.ctrl = r.ctrl;
      endcase
    end
    // a new event beats a clear in the same cycle
    n.status = n.status | ev;
    n.irq = |(n.status & n.mask);

    // bus address phase; read data comes from next values so a write forwards
    n.ap_valid = acc;
    n.ap_write = i_hwrite;
    n.ap_addr  = i_haddr[7:0];
    n.hrdata   = 32'h0000_0000;
    if (acc && !i_hwrite) begin
      unique case (i_haddr[7:0])
        `REG_STATUS: n.hrdata = {26'h000_0000, n.status};
        `REG_MASK:   n.hrdata = {26'h000_0000, n.mask};
        `REG_CTRL:   n.hrdata = {30'h0000_0000, n.ctrl};
        `REG_STATE:  n.hrdata = {16'h0000, s_cc1, s_cc2, n.th, !n.hicur_n,
                                 n.vconn2, n.vconn1, n.chg_on, n.debug, n.audio,
                                 !n.orient_n, !n.ufp_n, !n.fault_n};
        default:     n.hrdata = 32'h0000_0000;
      endcase
    end
    n.hready = 1'b1;
    n.hresp  = 1'b0;
  end

  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= RESET_S;
    end else begin
      r <= n;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign o_fault_n            = r.fault_n;
  assign o_plug_orientation_n = r.orient_n;
  assign o_ufp_n              = r.ufp_n;
  assign o_audio_n            = r.audio_n;
  assign o_debug_n            = r.debug_n;
  assign o_high_current_n     = r.hicur_n;
  assign o_charging_supply_on = r.chg_on;
  assign o_cable_power_cc1_on = r.vconn1;
  assign o_cable_power_cc2_on = r.vconn2;
  assign o_hrdata             = r.hrdata;
  assign o_hreadyout          = r.hready;
  assign o_hresp              = r.hresp;
  assign o_irq                = r.irq;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_b);

  chk_fault_oc: assert property (
    (gate && oc_dg && r.chg_on) |=> !o_fault_n)
    else $error("overcurrent did not pull fault low");

  chk_oc_filter: assert property (
    ($rose(s_oc) && r.th == TH_RUN && !oc_dg) |=> o_fault_n)
    else $error("unfiltered overcurrent reached fault");

  chk_fault_release: assert property (
    (gate && !oc_dg && r.th == TH_RUN) |=> o_fault_n)
    else $error("fault held after cause cleared");

  chk_thermal_hold: assert property (
    (r.th == TH_HOLD && en_eff) |=> (!o_fault_n && !o_charging_supply_on))
    else $error("lower thermal trip not handled");

  chk_shutdown_open: assert property (
    (r.th == TH_SHUT) |=> (o_fault_n && o_ufp_n && o_plug_orientation_n
      && o_audio_n && o_debug_n && o_high_current_n && !o_charging_supply_on))
    else $error("outputs driven in thermal shutdown");

  chk_restart: assert property (
    (r.th == TH_SHUT && !s_cooled) |=> (r.th == TH_SHUT) ##0
    (s_cooled [*1]) |=> (r.th == TH_RUN))
    else $error("no restart after cooling");

  chk_audio_set: assert property (
    (gate && s_cc1 == CC_RA && s_cc2 == CC_RA) |=> !o_audio_n)
    else $error("audio accessory not flagged");

  chk_audio_clear: assert property (
    (r.audio && s_cc2 != CC_RA) |=> o_audio_n)
    else $error("audio not released on cc2 removal");

  chk_debug_set: assert property (
    (gate && s_cc1 == CC_RD && s_cc2 == CC_RD) |=> !o_debug_n)
    else $error("debug accessory not flagged");

  chk_debug_clear: assert property (
    (r.debug && s_cc1 != CC_RD) |=> o_debug_n)
    else $error("debug not released on cc1 removal");

  chk_orient_idle: assert property (
    o_ufp_n |-> o_plug_orientation_n)
    else $error("orientation asserted with no ufp");

  chk_orient_cc2: assert property (
    (ufp && s_cc2 == CC_RD) |=> (!o_plug_orientation_n && !o_ufp_n))
    else $error("reverse orientation not reported");

  chk_disable: assert property (
    !en_eff |=> (o_ufp_n && o_fault_n && o_audio_n && o_debug_n && o_plug_orientation_n
      && !o_charging_supply_on && !o_cable_power_cc1_on && !o_cable_power_cc2_on))
    else $error("disabled port still active");

  chk_charge_dg: assert property (
    $rose(ufp_cand) |=> !o_charging_supply_on [*2])
    else $error("charging switch closed before deglitch");

  chk_hicur: assert property (
    (gate && r.chg_on && s_load_hi) |=> !o_high_current_n)
    else $error("high current flag missing");

  chk_vconn: assert property (
    (ufp && r.th == TH_RUN && r.ctrl[`CTRL_VCONN_BIT] && s_cc1 == CC_RD
     && s_cc2 == CC_RA) |=> o_cable_power_cc2_on)
    else $error("cable power not applied");

  cov_ufp_attach: cover property ($fell(o_ufp_n));
  cov_audio: cover property ($fell(o_audio_n));
  cov_debug: cover property ($fell(o_debug_n));
  cov_shutdown: cover property (r.th == TH_SHUT ##1 r.th == TH_RUN);
endmodule
`default_nettype wire

/* test/connector_far_side.sv */
`timescale 1ns/1ns
`default_nettype none
module connector_far_side
  import typec_port_pkg::*;
(
  // what is plugged in and how hard it pulls
  input  wire logic [2:0] i_kind,
  input  wire logic [1:0] i_load,
  // terminations and current levels seen at the port
  output logic      [1:0] o_cc1,
  output logic      [1:0] o_cc2,
  output logic            o_load_high,
  output logic            o_overcurrent
);
  // ****************************************************************
  // kinds: 0 none, 1 ufp, 2 ufp reversed, 3 ufp with cable on cc2,
  // 4 reversed ufp with cable on cc1, 5 audio, 6 debug, 7 cable on cc2
  // ****************************************************************
  always_comb begin
    o_cc1 = CC_OPEN;
    o_cc2 = CC_OPEN;
    case (i_kind)
      3'd1: o_cc1 = CC_RD;
      3'd2: o_cc2 = CC_RD;
      3'd3: begin
        o_cc1 = CC_RD;
        o_cc2 = CC_RA;
      end
      3'd4: begin
        o_cc1 = CC_RA;
        o_cc2 = CC_RD;
      end
      3'd5: begin
        o_cc1 = CC_RA;
        o_cc2 = CC_RA;
      end
      3'd6: begin
        o_cc1 = CC_RD;
        o_cc2 = CC_RD;
      end
      3'd7: o_cc2 = CC_RA;
      default: o_cc1 = CC_OPEN;
    endcase
  end
  // load 1 is above the compensation level, 2 is a hard overload
  assign o_load_high   = (i_load != 2'd0);
  assign o_overcurrent = (i_load == 2'd2);
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "typec_port_consts.svh"
module tb
  import typec_port_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        en;
  logic        th_low;
  logic        th_high;
  logic        th_cool;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rdat;
  logic [2:0]  kind;
  logic [1:0]  load;
  wire  logic [1:0]  cc1;
  wire  logic [1:0]  cc2;
  wire  logic        load_high;
  wire  logic        ovc;
  wire  logic [8:0]  outs;
  wire  logic [31:0] hrdata;
  wire  logic        hreadyout;
  wire  logic        hresp;
  wire  logic        irq;
  int          error_cnt;
  int          num_checks;
  localparam logic [8:0] IDLE = 9'h1f8;

  always #10 clk = ~clk;

  connector_far_side far (.i_kind(kind), .i_load(load), .o_cc1(cc1), .o_cc2(cc2),
    .o_load_high(load_high), .o_overcurrent(ovc));

  typec_source_port_status DUT (.i_clk(clk), .i_rst_b(rst_b), .i_cc1(cc1), .i_cc2(cc2),
    .i_en(en), .i_overcurrent(ovc), .i_thermal_low(th_low), .i_thermal_high(th_high),
    .i_thermal_cooled(th_cool), .i_load_high(load_high), .o_fault_n(outs[8]),
    .o_plug_orientation_n(outs[7]), .o_ufp_n(outs[6]), .o_audio_n(outs[5]),
    .o_debug_n(outs[4]), .o_high_current_n(outs[3]), .o_charging_supply_on(outs[2]),
    .o_cable_power_cc1_on(outs[1]), .o_cable_power_cc2_on(outs[0]), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_irq(irq));

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    give_verdict();
  endtask

  // outputs are looked at on the falling edge, well after they settle
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_bit(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (outs[idx] !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (outs[idx] !== val) begin
      give_up();
    end
  endtask

  // ****************************************************************
  // bus master, single word transfers
  // ****************************************************************
  task automatic ready_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      give_up();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    ready_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    ready_wait();
    rdat = hrdata;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
    check(hresp, 1'b0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    en = 1'b1;
    th_low = 1'b0;
    th_high = 1'b0;
    th_cool = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    kind = 3'd0;
    load = 2'd0;
    error_cnt = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    reg_chk(`REG_CTRL, 32'h0000_0003);
    reg_chk(`REG_MASK, 32'h0000_0000);
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    reg_chk(8'h10, 32'h0000_0000);
    check(outs, IDLE);
    $display("test registers done");
    // audio: removal only seen on cc2, so cc1 leaving keeps it
    @(posedge clk) kind <= 3'd5;
    wait_bit(5, 1'b0, 20);
    check(outs, 9'h1d8);
    @(posedge clk) kind <= 3'd7;
    cycles(10);
    check(outs, 9'h1d8);
    @(posedge clk) kind <= 3'd0;
    wait_bit(5, 1'b1, 20);
    check(outs, IDLE);
    check(irq, 1'b0);
    $display("test audio done");
    // debug: cc2 leaving keeps it, cc1 leaving ends it
    @(posedge clk) kind <= 3'd6;
    wait_bit(4, 1'b0, 20);
    check(outs, 9'h1e8);
    @(posedge clk) kind <= 3'd1;
    cycles(10);
    check(outs, 9'h1e8);
    @(posedge clk) kind <= 3'd2;
    wait_bit(4, 1'b1, 20);
    check(outs, IDLE);
    @(posedge clk) kind <= 3'd0;
    cycles(10);
    $display("test debug done");
    // attach with a cable, unmasked attach event
    ahb(1'b1, `REG_MASK, 32'h0000_0001);
    @(posedge clk) kind <= 3'd3;
    cycles(1500);
    check(outs, IDLE);
    wait_bit(6, 1'b0, 700);
    cycles(3);
    check(outs, 9'h1bd);
    check(irq, 1'b1);
    reg_chk(`REG_STATE, 32'h0000_92a2);
    ahb(1'b1, `REG_STATE, 32'h0000_0000);
    reg_chk(`REG_STATE, 32'h0000_92a2);
    reg_chk(`REG_STATUS, 32'h0000_0019);
    ahb(1'b1, `REG_STATUS, 32'h0000_0019);
    reg_chk(`REG_STATUS, 32'h0000_0000);
    cycles(2);
    check(irq, 1'b0);
    $display("test attach done");
    @(posedge clk) load <= 2'd1;
    wait_bit(3, 1'b0, 10);
    @(posedge clk) load <= 2'd0;
    wait_bit(3, 1'b1, 10);
    // a held overload reaches fault only after the filter, not within 100 cycles
    @(posedge clk) load <= 2'd2;
    cycles(100);
    check(outs[8], 1'b1);
    wait_bit(8, 1'b0, 400);
    @(posedge clk) load <= 2'd0;
    wait_bit(8, 1'b1, 20);
    reg_chk(`REG_STATUS, 32'h0000_0004);
    ahb(1'b1, `REG_STATUS, 32'h0000_0004);
    $display("test current done");
    @(posedge clk) th_low <= 1'b1;
    wait_bit(8, 1'b0, 10);
    check(outs[2], 1'b0);
    @(posedge clk) th_low <= 1'b0;
    wait_bit(8, 1'b1, 10);
    @(posedge clk) th_high <= 1'b1;
    wait_bit(6, 1'b1, 10);
    check(outs, IDLE);
    reg_chk(`REG_STATE, 32'h0000_9800);
    @(posedge clk) th_high <= 1'b0;
    cycles(20);
    check(outs, IDLE);
    @(posedge clk) th_cool <= 1'b1;
    wait_bit(6, 1'b0, 2100);
    @(posedge clk) th_cool <= 1'b0;
    $display("test thermal done");
    @(posedge clk) en <= 1'b0;
    wait_bit(6, 1'b1, 10);
    check(outs, IDLE);
    @(posedge clk) en <= 1'b1;
    wait_bit(6, 1'b0, 2100);
    ahb(1'b1, `REG_CTRL, 32'h0000_0002);
    wait_bit(6, 1'b1, 10);
    check(outs, IDLE);
    ahb(1'b1, `REG_CTRL, 32'h0000_0003);
    wait_bit(6, 1'b0, 2100);
    @(posedge clk) kind <= 3'd0;
    wait_bit(6, 1'b1, 10);
    check(outs, IDLE);
    ahb(1'b0, `REG_STATUS, 32'h0000_0000);
    check(rdat[1], 1'b1);
    $display("test enable done");
    @(posedge clk) kind <= 3'd4;
    wait_bit(6, 1'b0, 2100);
    cycles(3);
    check(outs, 9'h13e);
    // cable power withheld while software disallows it
    ahb(1'b1, `REG_CTRL, 32'h0000_0001);
    cycles(3);
    check(outs, 9'h13c);
    $display("test reverse done");
    give_verdict();
  end
endmodule
`default_nettype wire
